/* File: core/tcal_adc_monitor_regs.sv */
// APB register front end for the supply and temperature converter
// Operation
// - Writing one to the enable bit starts the converter, zero stops it
// - Latest supply sample sits in readings bits 7 to 0
// - Latest temperature sample sits in readings bits 15 to 8
// - Readings register is three octets, read-only, at index 03
// - Decode control 00, readings 03, wake-up 06, pulse generator 08 to 0C
module tcal_adc_monitor_regs
  import tcal_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic converter_en,
  input wire logic conv_done_tgl,
  input wire logic [7:0] conv_supply,
  input wire logic [7:0] conv_temp
);

  typedef enum logic [2:0] {
    TCAL_SEL_CTRL = 3'b000,
    TCAL_SEL_LATEST = 3'b001,
    TCAL_SEL_RSVD = 3'b010,
    TCAL_SEL_NONE = 3'b011
  } tcal_sel_t;

  logic ctrl_en_reg;
  logic [7:0] latest_supply_sample_reg;
  logic [7:0] latest_temperature_sample_reg;
  logic done_s1_reg;
  logic done_s2_reg;
  logic done_s3_reg;
  logic [7:0] supply_s1_reg;
  logic [7:0] supply_s2_reg;
  logic [7:0] temp_s1_reg;
  logic [7:0] temp_s2_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic done_evt;
  logic setup_ph;
  logic access_ph;
  tcal_sel_t sel;

  // Word address to sub-register selection; unaligned addresses fall to none
  function automatic tcal_sel_t decode(input logic [7:0] addr);
    logic [7:0] idx;
    idx = {2'b00, addr[7:TCAL_WORD_SHIFT]};
    if (addr[1:0] != 2'b00) begin
      decode = TCAL_SEL_NONE;
    end else if (idx == TCAL_IDX_CTRL) begin
      decode = TCAL_SEL_CTRL;
    end else if (idx == TCAL_IDX_LATEST) begin
      decode = TCAL_SEL_LATEST;
    end else if (idx == TCAL_IDX_WAKEUP || (idx >= TCAL_IDX_PG_FIRST && idx <= TCAL_IDX_PG_LAST)) begin
      decode = TCAL_SEL_RSVD;
    end else begin
      decode = TCAL_SEL_NONE;
    end
  endfunction : decode

  assign sel = decode(paddr);
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;

  // Zero wait states; read data was captured in the setup cycle
  assign pready = 1'b1;

  assign pslverr = access_ph && ((sel == TCAL_SEL_NONE) || (pwrite && sel == TCAL_SEL_LATEST));

  assign prdata = rdata_reg;
  assign converter_en = ctrl_en_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_en_reg <= TCAL_CTRL_RESET[TCAL_CTRL_EN_BIT];
    end else if (access_ph && pwrite && sel == TCAL_SEL_CTRL && pstrb[0]) begin
      ctrl_en_reg <= pwdata[TCAL_CTRL_EN_BIT];
    end
  end

  // Converter signals cross in from the analog side; data is stable before the toggle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      done_s1_reg <= 1'b0;
      done_s2_reg <= 1'b0;
      done_s3_reg <= 1'b0;
      supply_s1_reg <= TCAL_SAMPLE_RESET;
      supply_s2_reg <= TCAL_SAMPLE_RESET;
      temp_s1_reg <= TCAL_SAMPLE_RESET;
      temp_s2_reg <= TCAL_SAMPLE_RESET;
    end else begin
      done_s1_reg <= conv_done_tgl;
      done_s2_reg <= done_s1_reg;
      done_s3_reg <= done_s2_reg;
      supply_s1_reg <= conv_supply;
      supply_s2_reg <= supply_s1_reg;
      temp_s1_reg <= conv_temp;
      temp_s2_reg <= temp_s1_reg;
    end
  end

  assign done_evt = done_s2_reg ^ done_s3_reg;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      latest_supply_sample_reg <= TCAL_SAMPLE_RESET;
      latest_temperature_sample_reg <= TCAL_SAMPLE_RESET;
    end else if (done_evt && ctrl_en_reg) begin
      latest_supply_sample_reg <= supply_s2_reg;
      latest_temperature_sample_reg <= temp_s2_reg;
    end
  end

  // Reserved and unimplemented bits read as zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (sel)
      TCAL_SEL_CTRL: begin
        rdata_next[TCAL_CTRL_EN_BIT] = ctrl_en_reg;
      end
      TCAL_SEL_LATEST: begin
        rdata_next[TCAL_SUPPLY_LSB +: TCAL_SAMPLE_W] = latest_supply_sample_reg;
        rdata_next[TCAL_TEMP_LSB +: TCAL_SAMPLE_W] = latest_temperature_sample_reg;
      end
      TCAL_SEL_RSVD: begin
        rdata_next = 32'h0000_0000;
      end
      TCAL_SEL_NONE: begin
        rdata_next = 32'h0000_0000;
      end
      default: begin
        rdata_next = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      rdata_reg <= rdata_next;
    end
  end

  logic ctrl_wr;
  logic sample_upd;
  assign ctrl_wr = access_ph && pwrite && sel == TCAL_SEL_CTRL && pstrb[0];
  assign sample_upd = done_evt && ctrl_en_reg;

  AST_ENABLE_FOLLOWS_WRITE: assert property (@(posedge clk) disable iff (!rstn)
    ctrl_wr |=> converter_en == $past(pwdata[TCAL_CTRL_EN_BIT]))
    else $error("Enable did not follow the written bit");

  AST_ENABLE_HOLDS: assert property (@(posedge clk) disable iff (!rstn)
    !ctrl_wr |=> $stable(converter_en))
    else $error("Enable changed without a control write");

  AST_SUPPLY_CAPTURE: assert property (@(posedge clk) disable iff (!rstn)
    sample_upd |=> latest_supply_sample_reg == $past(supply_s2_reg))
    else $error("Supply sample not captured on completion");

  AST_TEMP_CAPTURE: assert property (@(posedge clk) disable iff (!rstn)
    sample_upd |=> latest_temperature_sample_reg == $past(temp_s2_reg))
    else $error("Temperature sample not captured on completion");

  AST_SAMPLES_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    !sample_upd |=> $stable({latest_temperature_sample_reg, latest_supply_sample_reg}))
    else $error("Samples changed without a completed conversion");

  AST_LATEST_READ_SHAPE: assert property (@(posedge clk) disable iff (!rstn)
    (setup_ph && !pwrite && sel == TCAL_SEL_LATEST) ##1 access_ph
      |-> prdata == {8'h00, $past(latest_temperature_sample_reg), $past(latest_supply_sample_reg)})
    else $error("Readings word read back wrongly");

  AST_LATEST_WRITE_REFUSED: assert property (@(posedge clk) disable iff (!rstn)
    (access_ph && pwrite && sel == TCAL_SEL_LATEST)
      |-> pslverr ##1 ($stable({latest_temperature_sample_reg, latest_supply_sample_reg}) || $past(sample_upd)))
    else $error("Write to readings not refused");

  AST_DECODE_ERR: assert property (@(posedge clk) disable iff (!rstn)
    (access_ph && !pwrite) |-> (pslverr == (sel == TCAL_SEL_NONE)))
    else $error("Decode error response wrong");

  AST_RESET_CLEARS: assert property (@(posedge clk) disable iff (!rstn)
    !$past(rstn) |-> !converter_en && latest_supply_sample_reg == 8'h00 && latest_temperature_sample_reg == 8'h00)
    else $error("State not cleared by reset");

  // Bus response: zero wait states, errors only in the access phase
  AST_PREADY_HIGH: assert property (@(posedge clk) disable iff (!rstn)
    pready == 1'b1)
    else $error("Ready dropped");

  AST_NO_ERR_OUTSIDE_ACCESS: assert property (@(posedge clk) disable iff (!rstn)
    !access_ph |-> !pslverr)
    else $error("Error response outside access phase");

  AST_UNALIGNED_ERR: assert property (@(posedge clk) disable iff (!rstn)
    (access_ph && paddr[1:0] != 2'b00) |-> pslverr)
    else $error("Unaligned access not refused");

  AST_RSVD_NO_ERR: assert property (@(posedge clk) disable iff (!rstn)
    (access_ph && sel == TCAL_SEL_RSVD) |-> !pslverr)
    else $error("Reserved index answered with error");

  AST_CTRL_NO_ERR: assert property (@(posedge clk) disable iff (!rstn)
    (access_ph && sel == TCAL_SEL_CTRL) |-> !pslverr)
    else $error("Control access answered with error");

  AST_LATEST_WRITE_ERR: assert property (@(posedge clk) disable iff (!rstn)
    (access_ph && pwrite && sel == TCAL_SEL_LATEST) |-> pslverr)
    else $error("Write to readings gave no error");

  AST_ERR_ONLY_REFUSED: assert property (@(posedge clk) disable iff (!rstn)
    (access_ph && pslverr) |-> (sel == TCAL_SEL_NONE) || (pwrite && sel == TCAL_SEL_LATEST))
    else $error("Error response for a legal access");

  // Read data shape per selected register
  AST_CTRL_READ_SHAPE: assert property (@(posedge clk) disable iff (!rstn)
    (setup_ph && !pwrite && sel == TCAL_SEL_CTRL) |=> prdata == {31'h0000_0000, $past(ctrl_en_reg)})
    else $error("Control word read back wrongly");

  AST_LATEST_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    (setup_ph && !pwrite && sel == TCAL_SEL_LATEST) |=> prdata[31:16] == 16'h0000)
    else $error("Readings upper bits not zero");

  AST_RSVD_READ_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    (setup_ph && !pwrite && sel == TCAL_SEL_RSVD) |=> prdata == 32'h0000_0000)
    else $error("Reserved index read not zero");

  AST_NONE_READ_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    (setup_ph && !pwrite && sel == TCAL_SEL_NONE) |=> prdata == 32'h0000_0000)
    else $error("Unmapped index read not zero");

  // Read data only moves on a read setup cycle
  AST_PRDATA_HOLDS: assert property (@(posedge clk) disable iff (!rstn)
    !(setup_ph && !pwrite) |=> $stable(prdata))
    else $error("Read data moved without a read");

  // Enable register write behaviour
  AST_ENABLE_SET: assert property (@(posedge clk) disable iff (!rstn)
    (ctrl_wr && pwdata[TCAL_CTRL_EN_BIT]) |=> converter_en)
    else $error("Enable not set by write of one");

  AST_ENABLE_CLEAR: assert property (@(posedge clk) disable iff (!rstn)
    (ctrl_wr && !pwdata[TCAL_CTRL_EN_BIT]) |=> !converter_en)
    else $error("Enable not cleared by write of zero");

  AST_STRB_GATES_WRITE: assert property (@(posedge clk) disable iff (!rstn)
    (access_ph && pwrite && sel == TCAL_SEL_CTRL && !pstrb[0]) |=> $stable(converter_en))
    else $error("Enable changed with its byte strobe low");

  AST_RSVD_WRITE_IGNORED: assert property (@(posedge clk) disable iff (!rstn)
    (access_ph && pwrite && sel == TCAL_SEL_RSVD) |=> $stable(converter_en))
    else $error("Reserved write touched the enable");

  AST_NONE_WRITE_IGNORED: assert property (@(posedge clk) disable iff (!rstn)
    (access_ph && pwrite && sel == TCAL_SEL_NONE) |=> $stable(converter_en))
    else $error("Unmapped write touched the enable");

  // Completion path: edge detect after the synchroniser, dropped while off
  AST_DONE_EVT_SOURCE: assert property (@(posedge clk) disable iff (!rstn)
    done_evt |-> $past(done_s1_reg) != $past(done_s2_reg))
    else $error("Completion event without a toggle");

  AST_DONE_OFF_DROPPED: assert property (@(posedge clk) disable iff (!rstn)
    (done_evt && !ctrl_en_reg) |=> $stable({latest_temperature_sample_reg, latest_supply_sample_reg}))
    else $error("Samples taken while converter off");

  AST_CHANGE_NEEDS_UPDATE: assert property (@(posedge clk) disable iff (!rstn)
    $changed({latest_temperature_sample_reg, latest_supply_sample_reg}) |-> $past(sample_upd))
    else $error("Samples changed without an accepted completion");

  // Scenario coverage
  COV_ENABLE_ON: cover property (@(posedge clk) disable iff (!rstn) ctrl_wr && pwdata[0]);
  COV_SAMPLE_UPD: cover property (@(posedge clk) disable iff (!rstn) sample_upd);
  COV_DONE_WHILE_OFF: cover property (@(posedge clk) disable iff (!rstn) done_evt && !ctrl_en_reg);
  COV_UNMAPPED: cover property (@(posedge clk) disable iff (!rstn) access_ph && sel == TCAL_SEL_NONE);
  COV_LATEST_READ: cover property (@(posedge clk) disable iff (!rstn)
    setup_ph && !pwrite && sel == TCAL_SEL_LATEST);

endmodule : tcal_adc_monitor_regs

/* File: core/tcal_pkg.sv */
// Register map and field constants for the converter control and readout block
package tcal_pkg;

  // Sub-register indices as laid out in the calibration file
  localparam logic [7:0] TCAL_IDX_CTRL = 8'h00;
  localparam logic [7:0] TCAL_IDX_LATEST = 8'h03;
  localparam logic [7:0] TCAL_IDX_WAKEUP = 8'h06;
  localparam logic [7:0] TCAL_IDX_PG_FIRST = 8'h08;
  localparam logic [7:0] TCAL_IDX_PG_LAST = 8'h0c;

  // Each index occupies one aligned 32-bit word on the bus
  localparam int TCAL_ADDR_W = 8;
  localparam int TCAL_WORD_SHIFT = 2;

  // adc_control fields
  localparam int TCAL_CTRL_W = 16;
  localparam int TCAL_CTRL_EN_BIT = 0;
  localparam logic [15:0] TCAL_CTRL_RESET = 16'h0000;

  // adc_latest_readings fields
  localparam int TCAL_LATEST_W = 24;
  localparam int TCAL_SUPPLY_LSB = 0;
  localparam int TCAL_TEMP_LSB = 8;
  localparam int TCAL_SAMPLE_W = 8;
  localparam logic [7:0] TCAL_SAMPLE_RESET = 8'h00;

  // Software must hold the enable at least this long per conversion
  localparam int TCAL_CLK_PERIOD_NS = 50;
  localparam int TCAL_EN_MIN_NS = 2500;
  localparam int TCAL_EN_MIN_CYC = (TCAL_EN_MIN_NS + TCAL_CLK_PERIOD_NS - 1) / TCAL_CLK_PERIOD_NS;

endpackage : tcal_pkg

/* File: verif/tcal_adc_monitor_regs_tb_top.sv */
// Self-checking bench for the converter register front end
module tcal_adc_monitor_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tcal_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic conv_done_tgl = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [7:0] conv_supply = 8'h00;
  logic [7:0] conv_temp = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic converter_en;
  logic [31:0] rd;
  logic er;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;

  tcal_adc_monitor_regs dut_u (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .converter_en(converter_en), .conv_done_tgl(conv_done_tgl), .conv_supply(conv_supply),
    .conv_temp(conv_temp));

  initial begin
    forever #25 clk = ~clk;
  end

  // Hang guard: the whole run needs under two hundred cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Master holds the request until pready is seen high at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      failures++;
      $display("Error at %0t: no ready from slave", $time);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
    chk({31'h0, er}, {31'h0, exp_err});
  endtask : rchk

  // Data settles one edge ahead of the completion toggle
  task automatic conv(input logic [7:0] s, input logic [7:0] t);
    conv_supply <= s;
    conv_temp <= t;
    @(posedge clk);
    conv_done_tgl <= ~conv_done_tgl;
    repeat (6) @(posedge clk);
  endtask : conv

  task automatic t_reset();
    chk({31'h0, converter_en}, 32'h0);
    rchk(8'h00, 32'h0, 1'b0);
    rchk(8'h0c, 32'h0, 1'b0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_enable();
    apb(8'h00, 1'b1, 32'h1);
    chk({31'h0, converter_en}, 32'h1);
    rchk(8'h00, 32'h1, 1'b0);
    repeat (TCAL_EN_MIN_CYC) @(posedge clk);
    apb(8'h00, 1'b1, 32'h0);
    chk({31'h0, converter_en}, 32'h0);
    $display("test enable done");
  endtask : t_enable

  task automatic t_conv();
    apb(8'h00, 1'b1, 32'h1);
    conv(8'hff, 8'h00);
    rchk(8'h0c, 32'h000000ff, 1'b0);
    conv(8'h5a, 8'hc3);
    rchk(8'h0c, 32'h0000c35a, 1'b0);
    repeat (TCAL_EN_MIN_CYC) @(posedge clk);
    apb(8'h00, 1'b1, 32'h0);
    conv(8'h11, 8'h22);
    rchk(8'h0c, 32'h0000c35a, 1'b0);
    $display("test conversion done");
  endtask : t_conv

  task automatic t_map();
    apb(8'h0c, 1'b1, 32'h0000ffff);
    chk({31'h0, er}, 32'h1);
    rchk(8'h0c, 32'h0000c35a, 1'b0);
    rchk(8'h18, 32'h0, 1'b0);
    for (int i = 8; i <= 12; i++) begin
      rchk(8'(i * 4), 32'h0, 1'b0);
    end
    rchk(8'h04, 32'h0, 1'b1);
    rchk(8'h01, 32'h0, 1'b1);
    $display("test map done");
  endtask : t_map

  task automatic summarize();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_enable();
    t_conv();
    t_map();
    summarize();
  end
endmodule : tcal_adc_monitor_regs_tb_top
